// >>> core/hc_ctrl_regs.v
// Purpose: Posted write failure capture, organization identifier and controller flag pair
// Assumes: Avalon-MM slave with waitrequest, byte addresses, 32-bit data
// Notes: Capture words are left unreset; interrupt status and mask are local additions
`include "hc_regs_map.vh"
`default_nettype none

module hc_ctrl_regs #(
    parameter ADDR_W = 8,
    parameter OFFSET_W = 48,
    parameter BUS_W = 10,
    parameter NODE_W = 6
) (
    // Clock and reset
    input wire clk_i,
    input wire resetn_i,
    // Avalon-MM register slave
    input wire [ADDR_W-1:0] address_i,
    input wire read_i,
    input wire write_i,
    input wire [31:0] writedata_i,
    input wire [3:0] byteenable_i,
    output reg [31:0] readdata_o,
    output reg waitrequest_o,
    // Posted write failure report
    input wire pw_fail_i,
    input wire [OFFSET_W-1:0] pw_fail_offset_i,
    input wire [BUS_W-1:0] pw_fail_bus_i,
    input wire [NODE_W-1:0] pw_fail_node_i,
    // Link-side status
    input wire fetch_error_i,
    input wire soft_reset_done_i,
    // Controller flags
    output reg [31:0] ctrl_flags_o,
    output reg byte_swap_disable_o,
    // Interrupt
    output reg irq_o
);

    // Bus handshake states
    localparam ST_IDLE = 1'b0;
    localparam ST_ANSWER = 1'b1;

    // Register selects
    localparam SEL_NONE = 3'h0;
    localparam SEL_FAIL_LOW = 3'h1;
    localparam SEL_FAIL_HIGH = 3'h2;
    localparam SEL_ORG_ID = 3'h3;
    localparam SEL_FLAGS_SET = 3'h4;
    localparam SEL_FLAGS_CLR = 3'h5;
    localparam SEL_IRQ_STAT = 3'h6;
    localparam SEL_IRQ_MASK = 3'h7;

    // Byte enables widened to a bit mask
    function [31:0] lane_mask;
        input [3:0] be;
        begin
            lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        end
    endfunction

    // Word decode; misaligned addresses fall to unmapped
    function [2:0] decode;
        input [ADDR_W-1:0] addr;
        begin
            case (addr[7:0])
                `OFS_FAIL_LOW: begin
                    decode = SEL_FAIL_LOW;
                end
                `OFS_FAIL_HIGH: begin
                    decode = SEL_FAIL_HIGH;
                end
                `OFS_ORG_ID: begin
                    decode = SEL_ORG_ID;
                end
                `OFS_FLAGS_SET: begin
                    decode = SEL_FLAGS_SET;
                end
                `OFS_FLAGS_CLR: begin
                    decode = SEL_FLAGS_CLR;
                end
                `OFS_IRQ_STAT: begin
                    decode = SEL_IRQ_STAT;
                end
                `OFS_IRQ_MASK: begin
                    decode = SEL_IRQ_MASK;
                end
                default: begin
                    decode = SEL_NONE;
                end
            endcase
            if ((addr >> 8) != {ADDR_W{1'b0}}) begin
                decode = SEL_NONE;
            end
        end
    endfunction

    // Flag register image as software sees it
    function [31:0] flags_view;
        input [31:0] state;
        begin
            flags_view = (state & `FLAGS_STATE_MASK) | `FLAGS_RESET;
        end
    endfunction

    reg state_q;
    reg state_d;
    reg [31:0] flags_q;
    reg [31:0] flags_d;
    reg [`IRQ_WIDTH-1:0] stat_q;
    reg [`IRQ_WIDTH-1:0] stat_d;
    reg [`IRQ_WIDTH-1:0] mask_q;
    reg [`IRQ_WIDTH-1:0] mask_d;
    reg [31:0] rdata_mux;
    reg [`IRQ_WIDTH-1:0] stat_events;
    reg [`IRQ_WIDTH-1:0] stat_taken;
    reg [31:0] mask_wide;

    wire [31:0] fail_low;
    wire [31:0] fail_high;
    wire [2:0] sel;
    wire [31:0] wmask;
    wire commit;
    wire commit_wr;
    wire commit_rd;

    failure_capture #(
        .OFFSET_W(OFFSET_W),
        .BUS_W(BUS_W),
        .NODE_W(NODE_W)
    ) u_capture (
        .clk_i(clk_i),
        .fail_i(pw_fail_i),
        .offset_i(pw_fail_offset_i),
        .bus_i(pw_fail_bus_i),
        .node_i(pw_fail_node_i),
        .low_o(fail_low),
        .high_o(fail_high)
    );

    assign sel = decode(address_i);
    assign wmask = writedata_i & lane_mask(byteenable_i);
    // The edge where waitrequest is seen low completes the transfer
    assign commit = (state_q == ST_ANSWER);
    assign commit_wr = commit & write_i;
    assign commit_rd = commit & read_i;

    // Read multiplexer
    always @* begin
        rdata_mux = 32'h0000_0000;
        case (sel)
            SEL_FAIL_LOW: begin
                rdata_mux = fail_low;
            end
            SEL_FAIL_HIGH: begin
                rdata_mux = fail_high;
            end
            SEL_ORG_ID: begin
                rdata_mux = `ORG_ID_VALUE;
            end
            SEL_FLAGS_SET: begin
                rdata_mux = flags_view(flags_q);
            end
            SEL_FLAGS_CLR: begin
                rdata_mux = flags_view(flags_q);
            end
            SEL_IRQ_STAT: begin
                rdata_mux[`IRQ_WIDTH-1:0] = stat_q;
            end
            SEL_IRQ_MASK: begin
                rdata_mux[`IRQ_WIDTH-1:0] = mask_q;
            end
            default: begin
                rdata_mux = 32'h0000_0000;
            end
        endcase
    end

    // Handshake: one wait cycle, then completion
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (read_i | write_i) begin
                    state_d = ST_ANSWER;
                end
            end
            ST_ANSWER: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Controller flags next value
    always @* begin
        flags_d = flags_q;
        if (commit_wr && sel == SEL_FLAGS_SET) begin
            flags_d = flags_q | (wmask & `FLAGS_SET_MASK & ~32'h8000_0000);
            // Image-valid only arms while the link is held off
            if (wmask[`BIT_IMG_VALID] && !flags_q[`BIT_LINK_ON]) begin
                flags_d[`BIT_IMG_VALID] = 1'b1;
            end
        end
        if (commit_wr && sel == SEL_FLAGS_CLR) begin
            flags_d = flags_q & ~(wmask & `FLAGS_CLR_MASK);
        end
        // Hardware clear of bits 16 and 31 when the soft reset has run its course
        if (soft_reset_done_i) begin
            flags_d[`BIT_SOFT_RST] = 1'b0;
            flags_d[`BIT_IMG_VALID] = 1'b0;
        end
        // Hardware clear wins over a software set in the same cycle
        if (fetch_error_i) begin
            flags_d[`BIT_IMG_VALID] = 1'b0;
        end
        flags_d = flags_view(flags_d);
    end

    // Interrupt status: events set, a completed read clears what it returned
    always @* begin
        stat_events = {`IRQ_WIDTH{1'b0}};
        stat_events[`IRQ_EV_CAPTURE] = pw_fail_i;
        stat_events[`IRQ_EV_FETCH] = fetch_error_i & flags_q[`BIT_IMG_VALID];
        stat_taken = {`IRQ_WIDTH{1'b0}};
        if (commit_rd && sel == SEL_IRQ_STAT) begin
            // Only bits already shown to software are dropped
            stat_taken = readdata_o[`IRQ_WIDTH-1:0];
        end
        stat_d = (stat_q & ~stat_taken) | stat_events;
        mask_wide = {{(32-`IRQ_WIDTH){1'b0}}, mask_q};
        if (commit_wr && sel == SEL_IRQ_MASK) begin
            mask_wide = (mask_wide & ~lane_mask(byteenable_i)) | wmask;
        end
        // Only bits 1:0 of the low lane hold mask bits; the rest are dropped on purpose
        mask_d = mask_wide[`IRQ_WIDTH-1:0];
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= ST_IDLE;
            waitrequest_o <= 1'b1;
            readdata_o <= 32'h0000_0000;
            flags_q <= `FLAGS_RESET;
            stat_q <= `IRQ_RESET;
            mask_q <= `IRQ_RESET;
            ctrl_flags_o <= `FLAGS_RESET;
            byte_swap_disable_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            state_q <= state_d;
            waitrequest_o <= (state_d != ST_ANSWER);
            if (state_q == ST_IDLE && read_i) begin
                // Sampled one cycle ahead so data stand while waitrequest is low
                readdata_o <= rdata_mux;
            end
            flags_q <= flags_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            ctrl_flags_o <= flags_d;
            byte_swap_disable_o <= flags_d[`BIT_SWAP_DIS];
            irq_o <= |(stat_d & mask_d);
        end
    end

endmodule // hc_ctrl_regs

`default_nettype wire

// >>> core/hc_regs_map.vh
// Purpose: Offsets, field positions, reset values and timing for the controller register bank
// Assumes: Included by bare name from the core files
// Notes: Definitions only
`ifndef HC_REGS_MAP_VH
`define HC_REGS_MAP_VH

// Byte offsets on the register bus
`define OFS_FAIL_LOW 8'h38
`define OFS_FAIL_HIGH 8'h3C
`define OFS_ORG_ID 8'h40
`define OFS_FLAGS_SET 8'h50
`define OFS_FLAGS_CLR 8'h54
`define OFS_IRQ_STAT 8'h60
`define OFS_IRQ_MASK 8'h64

// Failure-offset-high field positions
`define SRC_BUS_MSB 31
`define SRC_BUS_LSB 22
`define SRC_NODE_MSB 21
`define SRC_NODE_LSB 16
`define OFS_HIGH_MSB 15

// Controller flag bit positions
`define BIT_IMG_VALID 31
`define BIT_SWAP_DIS 30
`define BIT_ACK_TARDY 29
`define BIT_PHY_PROG 23
`define BIT_PHY_ENH 22
`define BIT_CTL19 19
`define BIT_CTL18 18
`define BIT_LINK_ON 17
`define BIT_SOFT_RST 16

// Bits that a one at the set address may raise (bit 31 is gated further)
`define FLAGS_SET_MASK 32'hE04F_0000
// Bits that a one at the clear address may drop (bit 31 excluded)
`define FLAGS_CLR_MASK 32'h604F_0000
// Bits that hold state; all others read back from constants
`define FLAGS_STATE_MASK 32'hE04F_0000
// Reset value: bit 23 high, undefined bits taken as zero
`define FLAGS_RESET 32'h0080_0000

// Organization identifier; value is arbitrary
`define ORG_ID_VALUE 32'h00A5_5A00

// Interrupt status and mask layout
`define IRQ_WIDTH 2
`define IRQ_EV_CAPTURE 0
`define IRQ_EV_FETCH 1
`define IRQ_RESET 2'h0

// Bus answer: cycles from request taken to waitrequest low
`define BUS_ANSWER_CYCLES 1

`endif

// >>> core/failure_capture.v
// Purpose: Hold the destination offset and requester of the last failed posted write
// Assumes: fail_i is a one-cycle pulse with its fields valid in the same cycle
// Notes: Contents are left unreset on purpose; software only reads them
`include "hc_regs_map.vh"
`default_nettype none

module failure_capture #(
    parameter OFFSET_W = 48,
    parameter BUS_W = 10,
    parameter NODE_W = 6
) (
    // Clock
    input wire clk_i,
    // Capture request from the link side
    input wire fail_i,
    input wire [OFFSET_W-1:0] offset_i,
    input wire [BUS_W-1:0] bus_i,
    input wire [NODE_W-1:0] node_i,
    // Captured words
    output reg [31:0] low_o,
    output reg [31:0] high_o
);

    // No reset: a stale value is harmless and saves reset routing
    always @(posedge clk_i) begin
        if (fail_i) begin
            low_o <= offset_i[31:0];
            high_o[`OFS_HIGH_MSB:0] <= offset_i[47:32];
            high_o[`SRC_BUS_MSB:`SRC_BUS_LSB] <= bus_i;
            high_o[`SRC_NODE_MSB:`SRC_NODE_LSB] <= node_i;
        end
    end

endmodule // failure_capture

`default_nettype wire

// >>> verification/hc_ctrl_regs_asserts.sv
// Purpose: Bus, capture and flag checks for hc_ctrl_regs
// Assumes: Default widths of the bank
// Notes: Capture checks wait for a first failure
`include "hc_regs_map.vh"
`default_nettype none
module hc_ctrl_regs_chk (
    // Bus
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [31:0] readdata_o,
    input wire logic waitrequest_o,
    // Link side and flags
    input wire logic pw_fail_i,
    input wire logic [47:0] pw_fail_offset_i,
    input wire logic [9:0] pw_fail_bus_i,
    input wire logic [5:0] pw_fail_node_i,
    input wire logic fetch_error_i,
    input wire logic soft_reset_done_i,
    input wire logic [31:0] ctrl_flags_o,
    input wire logic byte_swap_disable_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic seen_q;
    logic [31:0] low_q, high_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) seen_q <= 1'b0;
        else if (pw_fail_i) seen_q <= 1'b1;
    end
    // Copies stay unreset: compared only once seen_q is high
    always_ff @(posedge clk_i) begin
        if (pw_fail_i) begin
            low_q <= pw_fail_offset_i[31:0];
            high_q <= {pw_fail_bus_i, pw_fail_node_i, pw_fail_offset_i[47:32]};
        end
    end
    sequence rd_at(logic [7:0] a);
        read_i && waitrequest_o && address_i == a;
    endsequence
    sequence wr_at(logic [7:0] a);
        write_i && waitrequest_o && address_i == a;
    endsequence
    bus_answer_a: assert property ((read_i || write_i) && waitrequest_o |=>
        !waitrequest_o ##1 waitrequest_o) else $error("bus answer");
    org_id_a: assert property (rd_at(`OFS_ORG_ID) |=>
        readdata_o == `ORG_ID_VALUE) else $error("org id");
    low_capture_a: assert property (rd_at(`OFS_FAIL_LOW) && seen_q && !pw_fail_i |=>
        readdata_o == low_q) else $error("offset low");
    high_capture_a: assert property (rd_at(`OFS_FAIL_HIGH) && seen_q && !pw_fail_i |=>
        readdata_o == high_q) else $error("offset high");
    swap_follow_a: assert property (
        byte_swap_disable_o == ctrl_flags_o[`BIT_SWAP_DIS]) else $error("swap");
    image_gate_a: assert property (wr_at(`OFS_FLAGS_SET) && ctrl_flags_o[17] &&
        !ctrl_flags_o[31] |-> ##2 !ctrl_flags_o[31]) else $error("image gate");
    image_hold_a: assert property ($fell(ctrl_flags_o[31]) |->
        $past(fetch_error_i) || $past(soft_reset_done_i)) else $error("image hold");
    soft_reset_a: assert property (soft_reset_done_i |=>
        !ctrl_flags_o[16] && !ctrl_flags_o[31]) else $error("soft reset");
    clear_ones_a: assert property (wr_at(`OFS_FLAGS_CLR) |-> ##2
        (ctrl_flags_o & $past(writedata_i, 2) & `FLAGS_CLR_MASK) == 32'h0) else $error("clear");
    fixed_bits_a: assert property (
        (ctrl_flags_o & ~`FLAGS_STATE_MASK) == `FLAGS_RESET) else $error("fixed bits");
endmodule // hc_ctrl_regs_chk
bind hc_ctrl_regs hc_ctrl_regs_chk i_chk (.clk_i(clk_i), .resetn_i(resetn_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .pw_fail_i(pw_fail_i),
    .pw_fail_offset_i(pw_fail_offset_i), .pw_fail_bus_i(pw_fail_bus_i),
    .pw_fail_node_i(pw_fail_node_i), .fetch_error_i(fetch_error_i),
    .soft_reset_done_i(soft_reset_done_i), .ctrl_flags_o(ctrl_flags_o),
    .byte_swap_disable_o(byte_swap_disable_o));
`default_nettype wire

// >>> verification/fail_source.sv
// Purpose: Remote node that reports failed posted writes
// Assumes: The bench calls send
// Notes: Fields flip once the pulse ends, so stale values cannot pass
`default_nettype none
module fail_source (
    // Clock
    input wire logic clk_i,
    // Failure report
    output logic fail_o,
    output logic [47:0] offset_o,
    output logic [9:0] bus_o,
    output logic [5:0] node_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial fail_o = 1'b0;
    task automatic send(input logic [47:0] o, input logic [9:0] b, input logic [5:0] n);
        @(posedge clk_i);
        fail_o <= 1'b1;
        offset_o <= o;
        bus_o <= b;
        node_o <= n;
        @(posedge clk_i);
        fail_o <= 1'b0;
        offset_o <= ~o;
        bus_o <= ~b;
        node_o <= ~n;
    endtask
endmodule // fail_source
`default_nettype wire

// >>> verification/posted_write_error_and_host_ctrl_regs_bench.sv
// Purpose: Self-checking bench for the controller register bank
// Assumes: hc_regs_map.vh on the include path
// Notes: Byte lanes held on; partial writes untested
`include "hc_regs_map.vh"
`default_nettype none
`define CHK(n, e, s) checks_done++; if ((s) !== (e)) begin \
    $display("Error %s expected %h seen %h", n, e, s); mismatches++; end
module posted_write_error_and_host_ctrl_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, resetn_i = 1'b0, read_i = 1'b0, write_i = 1'b0;
    logic fetch_error_i = 1'b0, soft_reset_done_i = 1'b0;
    logic [7:0] address_i = 8'h0;
    logic [31:0] writedata_i = 32'h0, q;
    wire pw_fail_i, waitrequest_o, byte_swap_disable_o, irq_o;
    wire [47:0] pw_fail_offset_i;
    wire [9:0] pw_fail_bus_i;
    wire [5:0] pw_fail_node_i;
    wire [31:0] readdata_o, ctrl_flags_o;
    int mismatches = 0, checks_done = 0, cyc = 0;
    always #2.5 clk_i = ~clk_i;
    hc_ctrl_regs i_hc_ctrl_regs (.clk_i(clk_i), .resetn_i(resetn_i), .address_i(address_i),
        .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(4'hF),
        .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .pw_fail_i(pw_fail_i),
        .pw_fail_offset_i(pw_fail_offset_i), .pw_fail_bus_i(pw_fail_bus_i),
        .pw_fail_node_i(pw_fail_node_i), .fetch_error_i(fetch_error_i),
        .soft_reset_done_i(soft_reset_done_i), .ctrl_flags_o(ctrl_flags_o),
        .byte_swap_disable_o(byte_swap_disable_o), .irq_o(irq_o));
    fail_source i_fail_source (.clk_i(clk_i), .fail_o(pw_fail_i), .offset_o(pw_fail_offset_i),
        .bus_o(pw_fail_bus_i), .node_o(pw_fail_node_i));
    // Request held until the rising edge that sees waitrequest low; released at that edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        address_i <= a;
        writedata_i <= d;
        read_i <= !w;
        write_i <= w;
        do @(posedge clk_i); while (waitrequest_o !== 1'b0);
        q = readdata_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        xfer(1'b0, a, 32'h0);
        `CHK(n, e, q)
    endtask
    task automatic ev(input logic f, input logic s);
        @(posedge clk_i);
        fetch_error_i <= f;
        soft_reset_done_i <= s;
        @(posedge clk_i);
        fetch_error_i <= 1'b0;
        soft_reset_done_i <= 1'b0;
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            results();
        end
    end
    initial begin
        repeat (8) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd(`OFS_FLAGS_SET, `FLAGS_RESET, "flags set");
        rd(`OFS_FLAGS_CLR, `FLAGS_RESET, "flags clr");
        xfer(1'b1, `OFS_ORG_ID, 32'hFFFF_FFFF);
        rd(`OFS_ORG_ID, `ORG_ID_VALUE, "org id");
        rd(8'h44, 32'h0, "unmapped");
        $display("test reset done");
        xfer(1'b1, `OFS_IRQ_MASK, 32'h1);
        i_fail_source.send(48'hA1B2_C3D4_E5F6, 10'h2A5, 6'h1B);
        xfer(1'b1, `OFS_FAIL_LOW, 32'hFFFF_FFFF);
        rd(`OFS_FAIL_LOW, 32'hC3D4_E5F6, "low");
        rd(`OFS_FAIL_HIGH, {10'h2A5, 6'h1B, 16'hA1B2}, "high");
        `CHK("irq", 1'b1, irq_o)
        rd(`OFS_IRQ_STAT, 32'h1, "status");
        repeat (2) @(negedge clk_i);
        `CHK("irq off", 1'b0, irq_o)
        i_fail_source.send(48'hFFFF_FFFF_FFFF, 10'h3FF, 6'h3F);
        rd(`OFS_FAIL_HIGH, 32'hFFFF_FFFF, "high again");
        $display("test capture done");
        xfer(1'b1, `OFS_FLAGS_SET, 32'hFFFF_FFFF);
        rd(`OFS_FLAGS_CLR, 32'hE0CF_0000, "set all");
        `CHK("swap", 1'b1, byte_swap_disable_o)
        xfer(1'b1, `OFS_FLAGS_CLR, 32'hFFFF_FFFF);
        rd(`OFS_FLAGS_SET, 32'h8080_0000, "clear all");
        `CHK("flags", 32'h8080_0000, ctrl_flags_o)
        xfer(1'b1, `OFS_FLAGS_SET, 32'h0);
        rd(`OFS_FLAGS_SET, 32'h8080_0000, "zeros");
        ev(1'b1, 1'b0);
        rd(`OFS_FLAGS_SET, `FLAGS_RESET, "fetch");
        rd(`OFS_IRQ_STAT, 32'h3, "status both");
        xfer(1'b1, `OFS_FLAGS_SET, 32'h0003_0000);
        xfer(1'b1, `OFS_FLAGS_SET, 32'h8000_0000);
        rd(`OFS_FLAGS_SET, 32'h0083_0000, "gated");
        ev(1'b0, 1'b1);
        rd(`OFS_FLAGS_SET, 32'h0082_0000, "soft reset");
        $display("test flags done");
        results();
    end
endmodule // posted_write_error_and_host_ctrl_regs_bench
`default_nettype wire
